// ---- pkg/aluexe_pkg.sv ----
package aluexe_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned PC_W = 15;
  localparam int unsigned OFS_W = 9;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned DEC_W = 12;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_INSTR = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PC = 12'h00C;
  localparam logic [11:0] OFS_CYCLES = 12'h010;
  localparam logic [2:0] FILE_REGION = 3'h1;
  localparam int unsigned FILE_REGION_LSB = 9;
  localparam int unsigned FILE_IDX_LSB = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [31:0] CYCLES_RST = 32'h0000_0000;
  localparam logic [31:0] INSTR_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP,
    OP_ADD_ACC_TO_FILE,
    OP_ADD_ACC_FILE_WITH_CARRY,
    OP_ARITH_SHIFT_RIGHT_FILE,
    OP_CLEAR_FILE_BIT,
    OP_TEST_BIT_SKIP_IF_ZERO,
    OP_RELATIVE_JUMP
  } aluexe_op_type;

  typedef struct packed {
    logic [8:0] rsvd;
    logic [OFS_W-1:0] offset;
    logic [FADDR_W-1:0] faddr;
    logic [BIT_W-1:0] bit_idx;
    logic dest;
    aluexe_op_type op;
  } aluexe_instr_type;

  // status register layout: bit0 carry, bit1 half carry, bit2 zero
  typedef struct packed {
    logic zero;
    logic half_carry_flag;
    logic carry;
  } aluexe_flags_type;

  localparam aluexe_flags_type FLAGS_RST = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SECOND
  } aluexe_state_type;

endpackage

// ---- src/aluexe_alu.sv ----
`timescale 1ns/1ps

module aluexe_alu
  import aluexe_pkg::*;
(
  input wire aluexe_op_type op,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [DATA_W-1:0] fval,
  input wire logic carry_in,
  input wire logic [BIT_W-1:0] bit_idx,
  output logic [DATA_W-1:0] value,
  output aluexe_flags_type flags,
  output aluexe_flags_type flag_upd,
  output logic skip
);

  logic cin;
  logic [DATA_W:0] sum;
  logic [4:0] half;

  always_comb begin
    cin = (op == OP_ADD_ACC_FILE_WITH_CARRY) ? carry_in : 1'b0;
    sum = {1'b0, acc} + {1'b0, fval} + {8'h00, cin};
    half = {1'b0, acc[3:0]} + {1'b0, fval[3:0]} + {4'h0, cin};
    value = fval;
    flags = '0;
    flag_upd = '0;
    skip = 1'b0;
    unique case (op)
      OP_ADD_ACC_TO_FILE, OP_ADD_ACC_FILE_WITH_CARRY: begin
        value = sum[DATA_W-1:0];
        flags.carry = sum[DATA_W];
        flags.half_carry_flag = half[4];
        flag_upd = 3'h7;
      end
      OP_ARITH_SHIFT_RIGHT_FILE: begin
        value = {fval[7], fval[7:1]};
        flags.carry = fval[0];
        flag_upd.carry = 1'b1;
        flag_upd.zero = 1'b1;
      end
      OP_CLEAR_FILE_BIT: begin
        value = fval & ~(8'h01 << bit_idx);
      end
      OP_TEST_BIT_SKIP_IF_ZERO: begin
        skip = ~fval[bit_idx];
      end
      default: begin
        value = fval;
      end
    endcase
    flags.zero = (value == 8'h00);
  end

endmodule // aluexe_alu

// ---- src/aluexe_core.sv ----
`timescale 1ns/1ps

//
// Behaviour
// - add accumulator and file, destination selectable
// - add updates carry, half carry, zero
// - add with carry includes carry flag
// - shift right keeps msb, lsb into carry
// - shift touches carry and zero only
// - bit clear zeroes one bit, flags kept
// - bit test skips next when bit zero
// - relative jump target pc plus one plus offset
// - relative jump two cycles, flags kept
// - pc change or true test costs two cycles
module aluexe_core
  import aluexe_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic dp_valid_r, dp_valid_nxt;
  logic dp_write_r, dp_write_nxt;
  logic [DEC_W-1:0] dp_addr_r, dp_addr_nxt;
  logic rd_wait_r, rd_wait_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [DATA_W-1:0] file_mem [0:FILE_DEPTH-1];
  logic mem_we;
  logic [FADDR_W-1:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  aluexe_flags_type flags_r, flags_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [31:0] cycles_r, cycles_nxt;
  aluexe_instr_type instr_r, instr_nxt;
  aluexe_state_type state_r, state_nxt;
  logic busy;
  logic bus_wr;
  logic in_file;
  logic [FADDR_W-1:0] bus_fidx;
  logic [DATA_W-1:0] fval;
  logic [DATA_W-1:0] alu_value;
  aluexe_flags_type alu_flags;
  aluexe_flags_type alu_upd;
  logic alu_skip;
  logic [PC_W-1:0] jump_target;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  assign busy = (state_r != ST_IDLE);
  assign bus_wr = dp_valid_r && dp_write_r && !busy;
  assign in_file = (dp_addr_r[DEC_W-1:FILE_REGION_LSB] == FILE_REGION);
  assign bus_fidx = dp_addr_r[FILE_IDX_LSB +: FADDR_W];
  // reads take one wait state; everything stalls while an instruction runs
  assign hreadyout = !dp_valid_r || (dp_write_r ? !busy : rd_wait_r);
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;

  always_comb begin
    dp_valid_nxt = dp_valid_r;
    dp_write_nxt = dp_write_r;
    dp_addr_nxt = dp_addr_r;
    if (hready) begin
      dp_valid_nxt = hsel && htrans[1];
      dp_write_nxt = hwrite;
      dp_addr_nxt = haddr[DEC_W-1:0];
    end
    rd_wait_nxt = dp_valid_r && !dp_write_r && !busy && !rd_wait_r;
    hrdata_nxt = hrdata_r;
    if (rd_wait_nxt) begin
      hrdata_nxt = 32'h0000_0000;
      if (in_file) begin
        hrdata_nxt = {24'h00_0000, file_mem[bus_fidx]};
      end else begin
        unique case (dp_addr_r)
          OFS_INSTR: hrdata_nxt = instr_r;
          OFS_ACC: hrdata_nxt = {24'h00_0000, acc_r};
          OFS_STATUS: hrdata_nxt = {29'h0000_0000, flags_r};
          OFS_PC: hrdata_nxt = {17'h0_0000, pc_r};
          OFS_CYCLES: hrdata_nxt = cycles_r;
          default: hrdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 12'h000;
      rd_wait_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      dp_valid_r <= dp_valid_nxt;
      dp_write_r <= dp_write_nxt;
      dp_addr_r <= dp_addr_nxt;
      rd_wait_r <= rd_wait_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // execution
  // ---------------------------------------------------------------
  assign fval = file_mem[instr_r.faddr];
  assign jump_target = PC_W'(pc_r + 15'h0001 + {{(PC_W-OFS_W){instr_r.offset[OFS_W-1]}}, instr_r.offset});

  aluexe_alu u_alu (
    .op(instr_r.op),
    .acc(acc_r),
    .fval(fval),
    .carry_in(flags_r.carry),
    .bit_idx(instr_r.bit_idx),
    .value(alu_value),
    .flags(alu_flags),
    .flag_upd(alu_upd),
    .skip(alu_skip)
  );

  always_comb begin
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    pc_nxt = pc_r;
    cycles_nxt = cycles_r;
    instr_nxt = instr_r;
    state_nxt = state_r;
    mem_we = 1'b0;
    mem_wa = instr_r.faddr;
    mem_wd = alu_value;
    unique case (state_r)
      ST_IDLE: begin
        if (bus_wr) begin
          if (in_file) begin
            mem_we = 1'b1;
            mem_wa = bus_fidx;
            mem_wd = hwdata[DATA_W-1:0];
          end else begin
            unique case (dp_addr_r)
              OFS_INSTR: begin
                instr_nxt = aluexe_instr_type'(hwdata);
                state_nxt = ST_EXEC;
              end
              OFS_ACC: acc_nxt = hwdata[DATA_W-1:0];
              OFS_STATUS: flags_nxt = aluexe_flags_type'(hwdata[2:0]);
              OFS_PC: pc_nxt = hwdata[PC_W-1:0];
              default: ;
            endcase
          end
        end
      end
      ST_EXEC: begin
        cycles_nxt = cycles_r + 32'h0000_0001;
        pc_nxt = PC_W'(pc_r + 15'h0001);
        state_nxt = ST_IDLE;
        unique case (instr_r.op)
          OP_ADD_ACC_TO_FILE, OP_ADD_ACC_FILE_WITH_CARRY, OP_ARITH_SHIFT_RIGHT_FILE: begin
            if (instr_r.dest) begin
              mem_we = 1'b1;
            end else begin
              acc_nxt = alu_value;
            end
          end
          OP_CLEAR_FILE_BIT: mem_we = 1'b1;
          OP_TEST_BIT_SKIP_IF_ZERO: begin
            if (alu_skip) begin
              state_nxt = ST_SECOND;
            end
          end
          OP_RELATIVE_JUMP: begin
            pc_nxt = jump_target;
            state_nxt = ST_SECOND;
          end
          default: ;
        endcase
        if (alu_upd.carry) flags_nxt.carry = alu_flags.carry;
        if (alu_upd.half_carry_flag) flags_nxt.half_carry_flag = alu_flags.half_carry_flag;
        if (alu_upd.zero) flags_nxt.zero = alu_flags.zero;
      end
      ST_SECOND: begin
        // no-operation slot; a skip steps over the discarded word
        cycles_nxt = cycles_r + 32'h0000_0001;
        if (instr_r.op == OP_TEST_BIT_SKIP_IF_ZERO) begin
          pc_nxt = PC_W'(pc_r + 15'h0001);
        end
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= ACC_RST;
      flags_r <= FLAGS_RST;
      pc_r <= PC_RST;
      cycles_r <= CYCLES_RST;
      instr_r <= INSTR_RST;
      state_r <= ST_IDLE;
    end else begin
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      pc_r <= pc_nxt;
      cycles_r <= cycles_nxt;
      instr_r <= instr_nxt;
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [DATA_W:0] add_chk;
  logic [4:0] half_chk;
  logic is_exec_add;
  assign add_chk = {1'b0, acc_r} + {1'b0, fval};
  assign half_chk = {1'b0, acc_r[3:0]} + {1'b0, fval[3:0]};
  assign is_exec_add = (state_r == ST_EXEC) && (instr_r.op == OP_ADD_ACC_TO_FILE);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_add_to_acc: assert property (is_exec_add && !instr_r.dest |=> acc_r == $past(add_chk[7:0]))
    else $error("add to accumulator wrong");
  chk_add_to_file: assert property (is_exec_add && instr_r.dest |=>
    file_mem[$past(instr_r.faddr)] == $past(add_chk[7:0]) && acc_r == $past(acc_r))
    else $error("add to file wrong");
  chk_add_flags: assert property (is_exec_add |=> flags_r.carry == $past(add_chk[8])
    && flags_r.half_carry_flag == $past(half_chk[4]))
    else $error("add carry flags wrong");
  chk_addc_sum: assert property ((state_r == ST_EXEC) && (instr_r.op == OP_ADD_ACC_FILE_WITH_CARRY)
    && !instr_r.dest |=> acc_r == $past(8'(acc_r + fval + {7'h00, flags_r.carry})))
    else $error("add with carry wrong");
  chk_shift_result: assert property ((state_r == ST_EXEC) && (instr_r.op == OP_ARITH_SHIFT_RIGHT_FILE)
    && !instr_r.dest |=> acc_r == {$past(fval[7]), $past(fval[7:1])} && flags_r.carry == $past(fval[0]))
    else $error("shift result wrong");
  chk_shift_dc_kept: assert property ((state_r == ST_EXEC)
    && (instr_r.op == OP_ARITH_SHIFT_RIGHT_FILE) |=> $stable(flags_r.half_carry_flag))
    else $error("shift touched half carry");
  chk_clear_bit: assert property ((state_r == ST_EXEC) && (instr_r.op == OP_CLEAR_FILE_BIT) |=>
    file_mem[$past(instr_r.faddr)][$past(instr_r.bit_idx)] == 1'b0 && $stable(flags_r))
    else $error("bit clear wrong");
  chk_skip_taken: assert property ((state_r == ST_EXEC) && (instr_r.op == OP_TEST_BIT_SKIP_IF_ZERO)
    && !fval[instr_r.bit_idx] |=> state_r == ST_SECOND ##1
    (state_r == ST_IDLE && pc_r == 15'($past(pc_r, 2) + 15'h0002)))
    else $error("skip not taken in two cycles");
  chk_skip_not_taken: assert property ((state_r == ST_EXEC) && (instr_r.op == OP_TEST_BIT_SKIP_IF_ZERO)
    && fval[instr_r.bit_idx] |=> state_r == ST_IDLE && $stable(flags_r))
    else $error("skip wrongly taken");
  chk_jump_target: assert property ((state_r == ST_EXEC) && (instr_r.op == OP_RELATIVE_JUMP) |=>
    pc_r == $past(15'(pc_r + 15'h0001 + 15'($signed(instr_r.offset)))))
    else $error("jump target wrong");
  chk_jump_two: assert property ((state_r == ST_EXEC) && (instr_r.op == OP_RELATIVE_JUMP) |=>
    state_r == ST_SECOND ##1 (state_r == ST_IDLE && flags_r == $past(flags_r, 2)))
    else $error("jump not two cycles or flags changed");
  chk_zero_matches: assert property ((state_r == ST_EXEC) && !instr_r.dest
    && (instr_r.op inside {OP_ADD_ACC_TO_FILE, OP_ADD_ACC_FILE_WITH_CARRY, OP_ARITH_SHIFT_RIGHT_FILE})
    |=> flags_r.zero == (acc_r == 8'h00))
    else $error("zero flag does not match result");

endmodule // aluexe_core

// ---- sim/alu_bit_branch_exec_tb.sv ----
`timescale 1ns/1ps

module alu_bit_branch_exec_tb
  import aluexe_pkg::*;
;
  // ---------------------------------------------------------------
  // bus signals
  // ---------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] r;
  logic [31:0] c0;

  typedef struct {
    aluexe_op_type op;
    logic d;
    logic [2:0] b;
    logic [6:0] f;
    logic [8:0] o;
    logic [7:0] a, v;
    logic [2:0] s;
    logic [14:0] p;
    logic [7:0] ea, ev;
    logic [2:0] es;
    logic [14:0] ep;
    logic [1:0] ec;
  } aluexe_tb_row_type;

  // op, dest, bit, file, offset, acc, fval, status, pc -> acc, fval, status, pc, cycles
  aluexe_tb_row_type rows [15] = '{
    '{OP_ADD_ACC_TO_FILE, 1'b0, 3'h0, 7'h00, 9'h000, 8'h0F, 8'h01, 3'h0, 15'h0005, 8'h10, 8'h01, 3'h2, 15'h0006, 2'h1},
    '{OP_ADD_ACC_TO_FILE, 1'b1, 3'h0, 7'h7F, 9'h000, 8'h80, 8'h80, 3'h0, 15'h0006, 8'h80, 8'h00, 3'h5, 15'h0007, 2'h1},
    '{OP_ADD_ACC_FILE_WITH_CARRY, 1'b0, 3'h0, 7'h01, 9'h000, 8'hFF, 8'h00, 3'h1, 15'h0007, 8'h00, 8'h00, 3'h7, 15'h0008, 2'h1},
    '{OP_ADD_ACC_FILE_WITH_CARRY, 1'b1, 3'h0, 7'h02, 9'h000, 8'h12, 8'h34, 3'h6, 15'h0008, 8'h12, 8'h46, 3'h0, 15'h0009, 2'h1},
    '{OP_ARITH_SHIFT_RIGHT_FILE, 1'b0, 3'h0, 7'h03, 9'h000, 8'h00, 8'h81, 3'h2, 15'h0001, 8'hC0, 8'h81, 3'h3, 15'h0002, 2'h1},
    '{OP_ARITH_SHIFT_RIGHT_FILE, 1'b1, 3'h0, 7'h04, 9'h000, 8'h00, 8'h01, 3'h0, 15'h0001, 8'h00, 8'h00, 3'h5, 15'h0002, 2'h1},
    '{OP_ARITH_SHIFT_RIGHT_FILE, 1'b1, 3'h0, 7'h05, 9'h000, 8'h00, 8'h7E, 3'h7, 15'h0001, 8'h00, 8'h3F, 3'h2, 15'h0002, 2'h1},
    '{OP_CLEAR_FILE_BIT, 1'b1, 3'h7, 7'h06, 9'h000, 8'h00, 8'hFF, 3'h7, 15'h0001, 8'h00, 8'h7F, 3'h7, 15'h0002, 2'h1},
    '{OP_CLEAR_FILE_BIT, 1'b0, 3'h0, 7'h07, 9'h000, 8'h00, 8'h01, 3'h0, 15'h0001, 8'h00, 8'h00, 3'h0, 15'h0002, 2'h1},
    '{OP_TEST_BIT_SKIP_IF_ZERO, 1'b0, 3'h3, 7'h08, 9'h000, 8'h00, 8'h08, 3'h5, 15'h0010, 8'h00, 8'h08, 3'h5, 15'h0011, 2'h1},
    '{OP_TEST_BIT_SKIP_IF_ZERO, 1'b0, 3'h3, 7'h09, 9'h000, 8'h00, 8'hF7, 3'h5, 15'h0010, 8'h00, 8'hF7, 3'h5, 15'h0012, 2'h2},
    '{OP_RELATIVE_JUMP, 1'b0, 3'h0, 7'h0A, 9'h0FF, 8'h00, 8'h5A, 3'h7, 15'h0010, 8'h00, 8'h5A, 3'h7, 15'h0110, 2'h2},
    '{OP_RELATIVE_JUMP, 1'b0, 3'h0, 7'h0B, 9'h100, 8'h00, 8'h5A, 3'h2, 15'h0000, 8'h00, 8'h5A, 3'h2, 15'h7F01, 2'h2},
    '{OP_NOP, 1'b0, 3'h0, 7'h0C, 9'h000, 8'h33, 8'h5A, 3'h4, 15'h7FFF, 8'h33, 8'h5A, 3'h4, 15'h0000, 2'h1},
    '{aluexe_op_type'(3'h7), 1'b1, 3'h0, 7'h0D, 9'h000, 8'h33, 8'h5A, 3'h1, 15'h0003, 8'h33, 8'h5A, 3'h1, 15'h0004, 2'h1}
  };

  aluexe_core dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp)
  );

  always #2 hclk = ~hclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      n_fail++;
    end
  endtask

  // address phase, then data phase; each held until hready seen high
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic rdy;
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    for (int ph = 0; ph < 2; ph++) begin
      rdy = 1'b0;
      for (int n = 0; n < 20 && rdy !== 1'b1; n++) begin
        @(negedge hclk);
        rdy = hreadyout;
        rd = hrdata;
        @(posedge hclk);
      end
      if (rdy !== 1'b1) begin
        $display("wrong value at %0t: bus wait timed out", $time);
        n_fail++;
        test_done();
      end
      if (ph == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0000_0000, d);
  endtask

  function automatic logic [11:0] fa(input logic [6:0] f);
    return {FILE_REGION, f, 2'b00};
  endfunction

  function automatic logic [31:0] ins(aluexe_op_type op, logic d, logic [2:0] b, logic [6:0] f, logic [8:0] o);
    return {9'h000, o, f, b, d, op};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    aluexe_tb_row_type t;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      t = rows[i];
      wr(OFS_ACC, {24'h00_0000, t.a});
      wr(OFS_STATUS, {29'h0000_0000, t.s});
      wr(OFS_PC, {17'h0_0000, t.p});
      wr(fa(t.f), {24'h00_0000, t.v});
      rd(OFS_CYCLES, c0);
      wr(OFS_INSTR, ins(t.op, t.d, t.b, t.f, t.o));
      rd(OFS_ACC, r);
      chk(r, {24'h00_0000, t.ea}, "accumulator");
      rd(fa(t.f), r);
      chk(r, {24'h00_0000, t.ev}, "file register");
      rd(OFS_STATUS, r);
      chk(r, {29'h0000_0000, t.es}, "status flags");
      rd(OFS_PC, r);
      chk(r, {17'h0_0000, t.ep}, "program counter");
      rd(OFS_CYCLES, r);
      chk(r - c0, {30'h0000_0000, t.ec}, "cycle count");
    end
    // back-to-back instructions, carry handed from one to the next
    wr(OFS_ACC, 32'h0000_00F0);
    wr(OFS_STATUS, 32'h0000_0000);
    wr(fa(7'h20), 32'h0000_0020);
    wr(OFS_INSTR, ins(OP_ADD_ACC_TO_FILE, 1'b1, 3'h0, 7'h20, 9'h000));
    wr(OFS_INSTR, ins(OP_ADD_ACC_FILE_WITH_CARRY, 1'b0, 3'h0, 7'h20, 9'h000));
    rd(fa(7'h20), r);
    chk(r, 32'h0000_0010, "chained file");
    rd(OFS_ACC, r);
    chk(r, 32'h0000_0001, "chained acc");
    rd(OFS_STATUS, r);
    chk(r, 32'h0000_0001, "chained flags");
    rd(OFS_INSTR, r);
    chk(r, ins(OP_ADD_ACC_FILE_WITH_CARRY, 1'b0, 3'h0, 7'h20, 9'h000), "instr readback");
    // unmapped place and narrow register upper bits
    wr(12'h100, 32'hFFFF_FFFF);
    rd(12'h100, r);
    chk(r, 32'h0000_0000, "unmapped read");
    wr(OFS_ACC, 32'hFFFF_FFAA);
    rd(OFS_ACC, r);
    chk(r, 32'h0000_00AA, "acc width");
    chk({31'h0000_0000, hresp}, 32'h0000_0000, "response okay");
    // second reset in mid-run
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    chk({31'h0000_0000, hreadyout}, 32'h0000_0001, "ready in reset");
    chk(hrdata, 32'h0000_0000, "read data in reset");
    chk({31'h0000_0000, hresp}, 32'h0000_0000, "response in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 5; k++) begin
      rd(OFS_INSTR + 12'(4 * k), r);
      chk(r, 32'h0000_0000, "reset value");
    end
    test_done();
  end

endmodule // alu_bit_branch_exec_tb
